//--- asr_host.sv
// Host controller that drives the static memory pins
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module asr_host (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   reqValid,
    output logic                        reqReady,
    input  wire asr_pkg::asr_req_t      req,
    output logic                        rdValid,
    output logic [`ASR_DATA_W-1:0]      rdData,
    output asr_pkg::asr_pins_t          pins,
    input  wire logic [`ASR_DATA_W-1:0] dataIn
);
    // Bus cycle, one line per rising edge after the request is taken
    // Each step is one 100 ns cycle
    //
    // Read
    //   Edge 0: select and drive-enable fall together, address set
    //   Edge 1: access timer running, host off the data bus
    //   Edge 2: access timer running
    //   Edge 3: timer has run out, move to the sample step
    //   Edge 4: word sampled, select and drive-enable rise together
    //   Edge 4: answer strobe raised with the sampled word
    //   Edge 5: answer strobe falls, device outputs turning off
    //   Edge 6: back to idle, ready again
    //
    // Write
    //   Edge 0: select falls, address and data driven, drive-enable high
    //   Edge 1: address settle timer running
    //   Edge 2: write strobe falls
    //   Edge 3: strobe pulse timer running
    //   Edge 4: write strobe rises; this edge ends the write
    //   Edge 5: data and address still held past the end
    //   Edge 6: select rises, data released, back to idle
    //
    // Margins with the slowest grade at one cycle per step
    //   Access: 400 ns from select to sample, 200 ns needed
    //   Settle: 200 ns of address before the strobe, 20 ns needed
    //   Pulse: 200 ns of strobe low, 100 ns needed
    //   Hold: 200 ns of data after the strobe rises, 15 ns needed
    //   Release: 300 ns or more from device release to host drive
    //   Cycle: 600 ns or more per read and per write
    //
    // Data bus ownership
    //   Host drives only in write steps, drive-enable held high
    //   Device drives only in read steps, host output off
    //   Nobody drives in idle or in the turn-round step
    //   Host drive waits for the turn-round, so no contention
    //
    // Request handshake
    //   Ready is high exactly in idle
    //   Taken on an edge where valid and ready are both high
    //   Fields copied at that edge; the requester may change them after
    //   Writes get no answer; reads get a one-cycle strobe and a word
    //   The word stays until the next read
    //
    // After reset
    //   Select, write strobe and drive-enable high, host output off
    //   Address and data zero, no answer pending
    //   Memory sees a deselected, idle bus from the first edge with reset held
    //   Ready from the first edge with reset held, though requests are taken only once reset is low
    //
    // States
    //   Idle: deselected, waiting for a request
    //   Read set: select and drive-enable low, access time running
    //   Read wait: sample the word and release the bus
    //   Write set: address settles before the strobe
    //   Write pulse: strobe low for the pulse width
    //   Write hold: data held after the strobe rises
    //   Turn: device outputs float before the next cycle
    //
    // Limitations and trade-offs
    //   Each phase costs one cycle over its count: timer loads on entry
    //   That keeps one small timer for all phases, at some speed cost
    //   One request in flight; a busy controller just holds ready low
    //   Data bus taken as synchronous, no retiming stage
    //   An unknown state code falls back to idle, pins unchanged

    // All registered state of the controller in one word
    typedef struct packed {
        // Phase of the current bus cycle
        asr_pkg::asr_state_t     state;
        // Memory pins, registered so they never glitch
        asr_pkg::asr_pins_t      pins;
        // One-cycle read answer strobe
        logic                    rdValid;
        // Last word read, held until the next read
        logic [`ASR_DATA_W-1:0]  rdData;
    } asr_host_t;

    // Registered state and its next value
    asr_host_t st_q;
    asr_host_t st_d;
    logic       tLoad;   // Phase timer reload
    logic [3:0] tCount;  // Phase length in cycles, less one
    logic       tDone;   // Phase elapsed

    // Shared phase timer
    // Only one phase runs at a time, so one timer serves them all
    asr_timer u_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .load    (tLoad),
        .count   (tCount),
        .done    (tDone)
    );

    // Accept only when idle and the bus has settled
    // Combinational, so a request raised in idle is taken on the very
    // next edge without a wasted cycle
    assign reqReady = (st_q.state == asr_pkg::ST_IDLE);

    // Next-state logic
    // Defaults hold every register; the answer strobe drops each cycle
    // Timer reload is raised only on the edge that enters a phase
    always_comb begin
        st_d         = st_q;
        tLoad        = 1'b0;
        tCount       = 4'h0;
        st_d.rdValid = 1'b0;
        case (st_q.state)
            asr_pkg::ST_IDLE: begin
                // Chip deselected, all strobes high, host floats
                if (reqValid) begin
                    st_d.pins.addr = req.addr;
                    tLoad          = 1'b1;
                    if (req.write) begin
                        // Host drives data now, device floats with drive-enable high
                        st_d.pins.dataOut  = req.wdata;
                        st_d.pins.dataOeN  = 1'b0;
                        st_d.pins.outDriveN = 1'b1;
                        st_d.pins.chipSelN = 1'b0;
                        tCount             = 4'(`ASR_AS_CYC);
                        st_d.state         = asr_pkg::ST_WSET;
                    end else begin
                        // Select and enable together, host stays off bus
                        st_d.pins.dataOeN   = 1'b1;
                        st_d.pins.chipSelN  = 1'b0;
                        st_d.pins.outDriveN = 1'b0;
                        tCount              = 4'(`ASR_RD_CYC);
                        st_d.state          = asr_pkg::ST_RSET;
                    end
                end
            end
            asr_pkg::ST_RSET: begin
                // Wait out access time with write strobe high
                if (tDone) begin
                    st_d.state = asr_pkg::ST_RWAIT;
                end
            end
            asr_pkg::ST_RWAIT: begin
                // Sample then release select and enable together
                st_d.rdData         = dataIn;
                st_d.rdValid        = 1'b1;
                st_d.pins.chipSelN  = 1'b1;
                st_d.pins.outDriveN = 1'b1;
                tLoad               = 1'b1;
                tCount              = 4'(`ASR_TURN_CYC);
                st_d.state          = asr_pkg::ST_TURN;
            end
            asr_pkg::ST_WSET: begin
                // Address settle, then open the strobe
                if (tDone) begin
                    st_d.pins.writeStrobeN = 1'b0;
                    tLoad                  = 1'b1;
                    tCount                 = 4'(`ASR_WP_CYC);
                    st_d.state             = asr_pkg::ST_WPULS;
                end
            end
            asr_pkg::ST_WPULS: begin
                // Strobe rises first, ending the write
                if (tDone) begin
                    st_d.pins.writeStrobeN = 1'b1;
                    tLoad                  = 1'b1;
                    tCount                 = 4'(`ASR_WR_CYC);
                    st_d.state             = asr_pkg::ST_WHOLD;
                end
            end
            asr_pkg::ST_WHOLD: begin
                // Data and address held past the end of write
                if (tDone) begin
                    st_d.pins.chipSelN = 1'b1;
                    st_d.pins.dataOeN  = 1'b1;
                    st_d.state         = asr_pkg::ST_IDLE;
                end
            end
            asr_pkg::ST_TURN: begin
                // Let device outputs float before next cycle
                if (tDone) begin
                    st_d.state = asr_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d.state = asr_pkg::ST_IDLE;
            end
        endcase
    end

    // Register all state; reset deselects the memory
    // Reset is synchronous: pins keep their last values until the
    // first edge with reset high, then take the idle levels
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q                   <= '0;
            st_q.state             <= asr_pkg::ST_IDLE;
            st_q.pins.chipSelN     <= 1'b1;
            st_q.pins.writeStrobeN <= 1'b1;
            st_q.pins.outDriveN    <= 1'b1;
            st_q.pins.dataOeN      <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from flip-flops, with no logic between,
    // so the memory strobes cannot glitch between edges
    assign pins    = st_q.pins;
    assign rdValid = st_q.rdValid;
    assign rdData  = st_q.rdData;
endmodule : asr_host
`default_nettype wire

//--- asr_map.svh
// Constants for the static memory host controller
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_ADDR_W        11
`define ASR_DATA_W        8
`define ASR_CLK_MHZ       10
// Times in ns, slowest grade
`define ASR_T_RC_NS       200
`define ASR_T_AC_NS       200
`define ASR_T_AS_NS       20
`define ASR_T_WP_NS       100
`define ASR_T_WR_NS       10
`define ASR_T_DH_NS       15
`define ASR_T_OTD_NS      60
// Cycle counts, least times rounded up
`define ASR_CYC(ns)       ((((ns) * `ASR_CLK_MHZ) + 999) / 1000)
`define ASR_RD_CYC        `ASR_CYC(`ASR_T_AC_NS)
`define ASR_AS_CYC        `ASR_CYC(`ASR_T_AS_NS)
`define ASR_WP_CYC        `ASR_CYC(`ASR_T_WP_NS)
`define ASR_WR_CYC        `ASR_CYC(`ASR_T_WR_NS)
`define ASR_TURN_CYC      `ASR_CYC(`ASR_T_OTD_NS)
`endif

//--- asr_pkg.sv
// Types for the static memory host controller
`default_nettype none
`include "asr_map.svh"
package asr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RSET  = 3'b001,
        ST_RWAIT = 3'b010,
        ST_WSET  = 3'b011,
        ST_WPULS = 3'b100,
        ST_WHOLD = 3'b101,
        ST_TURN  = 3'b110
    } asr_state_t;

    // Host request
    typedef struct packed {
        logic                    write;
        logic [`ASR_ADDR_W-1:0]  addr;
        logic [`ASR_DATA_W-1:0]  wdata;
    } asr_req_t;

    // Memory pins driven by the host
    typedef struct packed {
        logic                    chipSelN;
        logic                    writeStrobeN;
        logic                    outDriveN;
        logic [`ASR_ADDR_W-1:0]  addr;
        logic [`ASR_DATA_W-1:0]  dataOut;
        logic                    dataOeN;
    } asr_pins_t;
endpackage : asr_pkg
`default_nettype wire

//--- asr_timer.sv
// Down counter that times each bus phase
`timescale 1ns/1ps
`default_nettype none
module asr_timer (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic [3:0] count,
    output logic            done
);
    typedef struct packed {
        logic [3:0] cnt;
    } asr_tmr_t;

    asr_tmr_t st_q;
    asr_tmr_t st_d;

    // Reload or count towards zero
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.cnt = count;
        end else if (st_q.cnt != 4'h0) begin
            st_d.cnt = st_q.cnt - 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Done once the count has run out; load stays out of this term,
    // since the controller loads on done and that would close a loop
    assign done = (st_q.cnt == 4'h0);
endmodule : asr_timer
`default_nettype wire

//--- asr_sram_model.sv
// Behavioural model of the static memory seen by the host
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module asr_sram_model (
    input  wire asr_pkg::asr_pins_t      pins,
    output logic [`ASR_DATA_W-1:0]       dataIn
);
    // Storage array, no clock or refresh needed
    logic [`ASR_DATA_W-1:0] mem [0:2047];
    logic                   wrOpen;          // Inside a write overlap
    logic [`ASR_ADDR_W-1:0] wrAddr;          // Address seen in overlap
    logic [`ASR_DATA_W-1:0] wrData;          // Data seen in overlap
    logic                   drive;           // Model drives the bus
    initial wrOpen = 1'b0;
    // Read only with select and drive-enable low, strobe high
    assign drive = !pins.chipSelN && pins.writeStrobeN && !pins.outDriveN;
    // Floating bus shows inverse of the word, never a stale copy
    assign dataIn = drive ? mem[pins.addr] : (!pins.dataOeN ? pins.dataOut : ~mem[pins.addr]);
    // Store at the first rise that ends the overlap
    always @(pins) begin
        if (!pins.chipSelN && !pins.writeStrobeN) begin
            wrOpen = 1'b1;
            wrAddr = pins.addr;
            wrData = pins.dataOut;
        end else if (wrOpen) begin
            mem[wrAddr] = wrData;
            wrOpen = 1'b0;
        end
    end
endmodule : asr_sram_model
`default_nettype wire

//--- asr_host_sva.sv
// Protocol checker for the memory host pins
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
module asr_host_sva (
    input wire logic                   sys_clk,
    input wire logic                   reset,
    input wire logic                   reqValid,
    input wire logic                   reqReady,
    input wire asr_pkg::asr_req_t      req,
    input wire logic                   rdValid,
    input wire logic [`ASR_DATA_W-1:0] rdData,
    input wire asr_pkg::asr_pins_t     pins,
    input wire logic [`ASR_DATA_W-1:0] dataIn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_no_contention: assert property (!pins.chipSelN && !pins.outDriveN |-> pins.dataOeN)
        else $error("host drives bus during read");
    chk_read_strobe: assert property (!pins.outDriveN |-> pins.writeStrobeN && !pins.chipSelN)
        else $error("read without proper controls");
    chk_write_overlap: assert property (!pins.writeStrobeN |-> !pins.chipSelN && !pins.dataOeN)
        else $error("write strobe outside select");
    chk_write_oe: assert property (!pins.writeStrobeN |-> pins.outDriveN)
        else $error("drive enable low during write");
    chk_write_end: assert property ($rose(pins.writeStrobeN) |-> !pins.chipSelN && $stable(pins.dataOut))
        else $error("write end not on strobe");
    chk_data_hold: assert property (!pins.writeStrobeN |=> $stable(pins.dataOut) && $stable(pins.addr))
        else $error("write data moved");
    chk_read_answer: assert property (reqValid && reqReady && !req.write |-> ##5 rdValid)
        else $error("read answer late");
    chk_answer_pulse: assert property (rdValid |=> !rdValid)
        else $error("read answer longer than one cycle");
    cov_read: cover property (rdValid);
    cov_write: cover property ($rose(pins.writeStrobeN));
    cov_turn: cover property (rdValid ##[1:12] !pins.writeStrobeN);
endmodule : asr_host_sva
bind asr_host asr_host_sva asr_host_sva_inst (.sys_clk(sys_clk), .reset(reset), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rdValid(rdValid), .rdData(rdData), .pins(pins), .dataIn(dataIn));
`default_nettype wire

//--- tb_asr_host.sv
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin failCount++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_asr_host;
    logic                    sys_clk = 1'b0;     // 100 ns clock
    logic                    reset = 1'b1;       // Sync reset
    logic                    reqValid = 1'b0;    // Request strobe
    logic                    reqReady;           // Controller idle
    asr_pkg::asr_req_t       req = '0;           // Request fields
    logic                    rdValid;            // Read answer pulse
    logic [`ASR_DATA_W-1:0]  rdData;             // Read word
    asr_pkg::asr_pins_t      pins;               // Memory controls
    logic [`ASR_DATA_W-1:0]  dataIn;             // Bus level
    logic [`ASR_DATA_W-1:0]  shadow [int];       // Expected contents
    int                      failCount = 0;
    int                      nChecks = 0;
    int                      cycles = 0;
    always #50 sys_clk = ~sys_clk;
    asr_host asr_host_inst (.sys_clk(sys_clk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
        .req(req), .rdValid(rdValid), .rdData(rdData), .pins(pins), .dataIn(dataIn));
    asr_sram_model asr_sram_model_inst (.pins(pins), .dataIn(dataIn));
    // Expected word at an address, from the bench's own copy
    function automatic logic [`ASR_DATA_W-1:0] expWord(input logic [`ASR_ADDR_W-1:0] a);
        return shadow[a];
    endfunction : expWord
    // One request, read answers compared with the shadow copy
    task automatic op(input logic wr, input logic [`ASR_ADDR_W-1:0] a, input logic [`ASR_DATA_W-1:0] d);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 50) begin
            @(posedge sys_clk); #1; n++;
        end
        `CHK("reqReady", 1'b1, reqReady)
        reqValid = 1'b1;
        req = '{write: wr, addr: a, wdata: d};
        @(posedge sys_clk); #1;
        reqValid = 1'b0;
        if (wr) shadow[a] = d;
        else begin
            n = 0;
            while (rdValid !== 1'b1 && n < 20) begin
                @(posedge sys_clk); #1; n++;
            end
            `CHK("rdValid", 1'b1, rdValid)
            `CHK("rdData", expWord(a), rdData)
        end
    endtask : op
    // Verdict and end of run
    task automatic conclude();
        if (failCount == 0 && nChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            failCount++;
            conclude();
        end
    end
    initial begin
        logic [`ASR_ADDR_W-1:0] a;
        void'($urandom(32'hb25f));
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        `CHK("idle select", 1'b1, pins.chipSelN)
        `CHK("idle bus", 1'b1, pins.dataOeN)
        // Corners: array ends and write then read back to back
        op(1'b1, 11'h000, 8'h5a);
        op(1'b1, 11'h7ff, 8'ha5);
        op(1'b0, 11'h7ff, 8'h00);
        op(1'b0, 11'h000, 8'h00);
        op(1'b1, 11'h000, 8'hff);
        op(1'b0, 11'h000, 8'h00);
        repeat (300) begin
            a = 11'($urandom);
            if ($urandom % 2 || !shadow.exists(a)) op(1'b1, a, 8'($urandom));
            else op(1'b0, a, 8'h00);
        end
        conclude();
    end
endmodule : tb_asr_host
`default_nettype wire
